//--- verilog/tdt2_pkg.sv
// constants for the timer data and third timer flag block
`default_nettype none
package tdt2_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FIRST_LOW = 8'h8A;
    localparam logic [7:0] IDX_SECOND_LOW = 8'h8B;
    localparam logic [7:0] IDX_FIRST_HIGH = 8'h8C;
    localparam logic [7:0] IDX_SECOND_HIGH = 8'h8D;
    localparam logic [7:0] IDX_PIN_FUNC = 8'h93;
    localparam logic [7:0] IDX_THIRD_CTRL = 8'hC8;
    localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;
    localparam logic [7:0] IDX_THIRD_LOW = 8'hCC;
    localparam logic [7:0] IDX_THIRD_HIGH = 8'hCD;
    // third timer control fields
    localparam int BIT_OVF_FLAG = 7;
    localparam int BIT_EDGE_FLAG = 6;
    localparam int BIT_RX_SEL = 5;
    localparam int BIT_TX_SEL = 4;
    localparam int BIT_EDGE_EN = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_CNT_SEL = 1;
    localparam int BIT_CAP_SEL = 0;
    // pin function select fields
    localparam int BIT_SECOND_OE = 5;
    localparam int BIT_FIRST_OE = 4;
    // reset values
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_PIN_FUNC = 8'h05;
    localparam logic [7:0] RST_THIRD_CTRL = 8'h00;
    // overflow dividers of the output pins
    localparam int FIRST_DIV = 64;
    localparam int SECOND_DIV = 2;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- verilog/tdt2_ovf_div.sv
// overflow rate divider driving a timer output pin
`default_nettype none
module tdt2_ovf_div #(
    parameter int DIV = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // overflow pulse in, divided square wave out
    input wire logic overflow,
    output logic divided
);
    localparam int HALF = DIV / 2;
    localparam int CW = $clog2(HALF + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF - 1);

    logic [CW-1:0] count;
    wire wrap = (count == LAST);

    // one toggle per half period gives a full period of DIV overflows
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= '0;
            divided <= 1'b0;
        end else if (ce && overflow) begin
            count <= wrap ? '0 : count + 1'b1;
            if (wrap) begin
                divided <= ~divided;
            end
        end
    end
endmodule
`default_nettype wire

//--- verilog/tdt2_timer_regs.sv
// timer count bytes, divided outputs and third timer with its flags
`default_nettype none
module tdt2_timer_regs #(
    parameter int ADDR_W = 12
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // first and second timer overflow pulses from the mode logic
    input wire logic first_overflow,
    input wire logic second_overflow,
    // first and second timer count values to the mode logic
    output logic [15:0] first_count,
    output logic [15:0] second_count,
    // divided output pins
    output logic first_divided_output,
    output logic first_divided_output_oe_n,
    output logic second_divided_output,
    output logic second_divided_output_oe_n,
    // third timer pins, asynchronous
    input wire logic external_trigger_pin,
    input wire logic third_count_pin,
    // serial baud clock pulses and third timer overflow pulse
    output logic rx_baud_tick,
    output logic tx_baud_tick,
    output logic third_overflow_pulse
);
    // mapped test on an index, used by both read and write paths
    function automatic logic tdt2_hit(input logic [ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        tdt2_hit = (addr[ADDR_W-1:10] == '0) &&
            (idx == tdt2_pkg::IDX_FIRST_LOW || idx == tdt2_pkg::IDX_SECOND_LOW ||
             idx == tdt2_pkg::IDX_FIRST_HIGH || idx == tdt2_pkg::IDX_SECOND_HIGH ||
             idx == tdt2_pkg::IDX_PIN_FUNC || idx == tdt2_pkg::IDX_THIRD_CTRL ||
             idx == tdt2_pkg::IDX_RELOAD_LOW || idx == tdt2_pkg::IDX_RELOAD_HIGH ||
             idx == tdt2_pkg::IDX_THIRD_LOW || idx == tdt2_pkg::IDX_THIRD_HIGH);
    endfunction

    // registers
    logic [7:0] first_count_low;
    logic [7:0] first_count_high;
    logic [7:0] second_count_low;
    logic [7:0] second_count_high;
    logic [7:0] pin_function_select;
    logic [7:0] third_timer_control;
    logic [15:0] third_count;
    logic [15:0] third_reload;

    // write channel state
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;

    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;
    assign arready = !rvalid;

    wire do_write = aw_held && w_held;
    wire wr_hit = tdt2_hit(wr_addr);
    wire [7:0] wr_idx = wr_addr[9:2];
    wire wr_ok = do_write && wr_hit && wr_lane;
    wire we_first_low = wr_ok && (wr_idx == tdt2_pkg::IDX_FIRST_LOW);
    wire we_first_high = wr_ok && (wr_idx == tdt2_pkg::IDX_FIRST_HIGH);
    wire we_second_low = wr_ok && (wr_idx == tdt2_pkg::IDX_SECOND_LOW);
    wire we_second_high = wr_ok && (wr_idx == tdt2_pkg::IDX_SECOND_HIGH);
    wire we_pin_func = wr_ok && (wr_idx == tdt2_pkg::IDX_PIN_FUNC);
    wire we_ctrl = wr_ok && (wr_idx == tdt2_pkg::IDX_THIRD_CTRL);
    wire we_reload_low = wr_ok && (wr_idx == tdt2_pkg::IDX_RELOAD_LOW);
    wire we_reload_high = wr_ok && (wr_idx == tdt2_pkg::IDX_RELOAD_HIGH);
    wire we_third_low = wr_ok && (wr_idx == tdt2_pkg::IDX_THIRD_LOW);
    wire we_third_high = wr_ok && (wr_idx == tdt2_pkg::IDX_THIRD_HIGH);

    // awprot and arprot carry no meaning here; every access is allowed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= '0;
            wr_byte <= 8'h00;
            wr_lane <= 1'b0;
            bvalid <= 1'b0;
            bresp <= tdt2_pkg::RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held <= 1'b1;
                wr_addr <= awaddr;
            end
            if (wvalid && wready) begin
                w_held <= 1'b1;
                wr_byte <= wdata[7:0];
                wr_lane <= wstrb[0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_hit ? tdt2_pkg::RESP_OKAY : tdt2_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read path; data sits in the low byte, upper bits read zero
    wire [7:0] rd_idx = araddr[9:2];
    wire rd_hit = tdt2_hit(araddr);
    wire [7:0] rd_byte =
        (rd_idx == tdt2_pkg::IDX_FIRST_LOW) ? first_count_low :
        (rd_idx == tdt2_pkg::IDX_FIRST_HIGH) ? first_count_high :
        (rd_idx == tdt2_pkg::IDX_SECOND_LOW) ? second_count_low :
        (rd_idx == tdt2_pkg::IDX_SECOND_HIGH) ? second_count_high :
        (rd_idx == tdt2_pkg::IDX_PIN_FUNC) ? pin_function_select :
        (rd_idx == tdt2_pkg::IDX_THIRD_CTRL) ? third_timer_control :
        (rd_idx == tdt2_pkg::IDX_RELOAD_LOW) ? third_reload[7:0] :
        (rd_idx == tdt2_pkg::IDX_RELOAD_HIGH) ? third_reload[15:8] :
        (rd_idx == tdt2_pkg::IDX_THIRD_LOW) ? third_count[7:0] :
        (rd_idx == tdt2_pkg::IDX_THIRD_HIGH) ? third_count[15:8] : 8'h00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= tdt2_pkg::RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_hit ? rd_byte : 8'h00};
                rresp <= rd_hit ? tdt2_pkg::RESP_OKAY : tdt2_pkg::RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // first and second count bytes and pin function select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_count_low <= tdt2_pkg::RST_COUNT;
            first_count_high <= tdt2_pkg::RST_COUNT;
            second_count_low <= tdt2_pkg::RST_COUNT;
            second_count_high <= tdt2_pkg::RST_COUNT;
            pin_function_select <= tdt2_pkg::RST_PIN_FUNC;
        end else if (ce) begin
            if (we_first_low) begin
                first_count_low <= wr_byte;
            end
            if (we_first_high) begin
                first_count_high <= wr_byte;
            end
            if (we_second_low) begin
                second_count_low <= wr_byte;
            end
            if (we_second_high) begin
                second_count_high <= wr_byte;
            end
            if (we_pin_func) begin
                pin_function_select <= wr_byte;
            end
        end
    end

    assign first_count = {first_count_high, first_count_low};
    assign second_count = {second_count_high, second_count_low};

    // divided outputs; dividers run regardless so enabling shows a phase-true wave
    tdt2_ovf_div #(
        .DIV(tdt2_pkg::FIRST_DIV)
    ) first_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .overflow(first_overflow),
        .divided(first_divided_output)
    );

    tdt2_ovf_div #(
        .DIV(tdt2_pkg::SECOND_DIV)
    ) second_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .overflow(second_overflow),
        .divided(second_divided_output)
    );

    assign first_divided_output_oe_n = ~pin_function_select[tdt2_pkg::BIT_FIRST_OE];
    assign second_divided_output_oe_n = ~pin_function_select[tdt2_pkg::BIT_SECOND_OE];

    // pin synchronisers: three stages, a level counts once stages two and three agree
    logic [2:0] trig_sync;
    logic [2:0] cnt_sync;
    logic trig_level;
    logic cnt_level;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync <= 3'h7;
            cnt_sync <= 3'h7;
            trig_level <= 1'b1;
            cnt_level <= 1'b1;
        end else if (ce) begin
            trig_sync <= {trig_sync[1:0], external_trigger_pin};
            cnt_sync <= {cnt_sync[1:0], third_count_pin};
            if (trig_sync[1] == trig_sync[2]) begin
                trig_level <= trig_sync[2];
            end
            if (cnt_sync[1] == cnt_sync[2]) begin
                cnt_level <= cnt_sync[2];
            end
        end
    end

    wire trig_fall = trig_level && !trig_sync[1] && !trig_sync[2];
    wire cnt_fall = cnt_level && !cnt_sync[1] && !cnt_sync[2];

    // third timer control decode
    wire run = third_timer_control[tdt2_pkg::BIT_RUN];
    wire cnt_sel = third_timer_control[tdt2_pkg::BIT_CNT_SEL];
    wire cap_sel = third_timer_control[tdt2_pkg::BIT_CAP_SEL];
    wire edge_en = third_timer_control[tdt2_pkg::BIT_EDGE_EN];
    wire rx_sel = third_timer_control[tdt2_pkg::BIT_RX_SEL];
    wire tx_sel = third_timer_control[tdt2_pkg::BIT_TX_SEL];
    wire baud_mode = rx_sel || tx_sel;

    // timer mode counts every second clock, counter mode on the count pin's fall
    logic prescale;
    wire tick = run && (cnt_sel ? cnt_fall : prescale);
    wire overflow = tick && (third_count == 16'hFFFF);
    wire edge_evt = edge_en && trig_fall;
    // baud use forces auto-reload; capture select is then ignored
    wire reload_now = (overflow && (baud_mode || !cap_sel)) ||
        (edge_evt && !baud_mode && !cap_sel);
    wire capture_now = edge_evt && !baud_mode && cap_sel;
    wire ovf_set = overflow && !baud_mode;
    // in baud mode a pin edge still flags, but moves no count
    wire edge_set = edge_evt;

    logic [15:0] next_third_count;
    logic [7:0] next_ctrl;

    always_comb begin
        next_third_count = third_count;
        if (reload_now) begin
            next_third_count = third_reload;
        end else if (tick) begin
            next_third_count = third_count + 16'h0001;
        end
        if (we_third_low) begin
            next_third_count[7:0] = wr_byte;
        end
        if (we_third_high) begin
            next_third_count[15:8] = wr_byte;
        end
    end

    // a flag set in the same cycle as a software clear survives
    always_comb begin
        next_ctrl = we_ctrl ? wr_byte : third_timer_control;
        next_ctrl[tdt2_pkg::BIT_OVF_FLAG] = next_ctrl[tdt2_pkg::BIT_OVF_FLAG] | ovf_set;
        next_ctrl[tdt2_pkg::BIT_EDGE_FLAG] = next_ctrl[tdt2_pkg::BIT_EDGE_FLAG] | edge_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescale <= 1'b0;
            third_count <= {tdt2_pkg::RST_COUNT, tdt2_pkg::RST_COUNT};
            third_reload <= {tdt2_pkg::RST_COUNT, tdt2_pkg::RST_COUNT};
            third_timer_control <= tdt2_pkg::RST_THIRD_CTRL;
        end else if (ce) begin
            prescale <= run && !cnt_sel && !prescale;
            third_count <= next_third_count;
            third_timer_control <= next_ctrl;
            if (we_reload_low) begin
                third_reload[7:0] <= wr_byte;
            end else if (capture_now) begin
                third_reload[7:0] <= third_count[7:0];
            end
            if (we_reload_high) begin
                third_reload[15:8] <= wr_byte;
            end else if (capture_now) begin
                third_reload[15:8] <= third_count[15:8];
            end
        end
    end

    // baud clock selection, registered so the pulses leave from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
            third_overflow_pulse <= 1'b0;
        end else if (ce) begin
            rx_baud_tick <= rx_sel ? overflow : second_overflow;
            tx_baud_tick <= tx_sel ? overflow : second_overflow;
            third_overflow_pulse <= overflow;
        end
    end
endmodule
`default_nettype wire

//--- testbench/tdt2_chk.sv
// port checker for the timer data and third timer flag block
`default_nettype none
module tdt2_chk (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // overflow pulses and divided pins
    input wire logic first_overflow,
    input wire logic second_overflow,
    input wire logic first_divided_output,
    input wire logic first_divided_output_oe_n,
    input wire logic second_divided_output,
    input wire logic second_divided_output_oe_n
);
    logic [4:0] ovf_cnt;
    // mirrors the pulse count so a wrong divide ratio shows at once
    always_ff @(posedge aclk) begin
        if (!aresetn) ovf_cnt <= 5'h00;
        else if (ce && first_overflow) ovf_cnt <= ovf_cnt + 5'h01;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_read_lat: assert property (arvalid && arready && ce |=> rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (rvalid && !(rready && ce) |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    chk_write_resp: assert property (awvalid && awready && wvalid && wready && ce ##1 ce
        |=> bvalid)
        else $error("write answer late");
    chk_resp_hold: assert property (bvalid && !(bready && ce) |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    chk_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    chk_read_busy: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    chk_byte_width: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    chk_second_div: assert property ((second_divided_output != $past(second_divided_output))
        == $past(second_overflow && ce && aresetn))
        else $error("second pin toggle wrong");
    chk_first_div: assert property ((first_divided_output != $past(first_divided_output))
        == $past(first_overflow && ce && aresetn && ovf_cnt == 5'h1F))
        else $error("first pin toggle wrong");
    chk_enable_write: assert property ($changed(first_divided_output_oe_n)
        || $changed(second_divided_output_oe_n) |-> $rose(bvalid))
        else $error("pin enable moved without write");
endmodule
bind tdt2_timer_regs tdt2_chk tdt2_chk_i (.aclk, .aresetn, .ce, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
    .first_overflow, .second_overflow, .first_divided_output, .first_divided_output_oe_n,
    .second_divided_output, .second_divided_output_oe_n);
`default_nettype wire

//--- testbench/tb_tdt2_timer_regs.sv
// self-checking bench for the timer data and third timer flag block
`default_nettype none
module tb_tdt2_timer_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'hF;
    logic first_overflow = 1'b0, second_overflow = 1'b0;
    logic external_trigger_pin = 1'b1, third_count_pin = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, rx_baud_tick, tx_baud_tick;
    logic first_divided_output, first_divided_output_oe_n, third_overflow_pulse;
    logic second_divided_output, second_divided_output_oe_n;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] first_count, second_count;
    logic [7:0] idxs [10] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h93, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
    int errors = 0, checked = 0, seed = 32'h70da3fd1, mdl [256], txn = 0, ovn = 0, i, t0;
    int rxn = 0, r0;
    // plain run, both baud selects, receive select only, transmit select only
    logic [7:0] ctl [4] = '{8'h04, 8'h34, 8'h24, 8'h14};
    tdt2_timer_regs #(.ADDR_W(12)) tdt2_timer_regs_i (.aclk, .aresetn, .ce, .awvalid, .awready,
        .awaddr, .awprot, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot, .rvalid, .rready, .rdata, .rresp, .first_overflow,
        .second_overflow, .first_count, .second_count, .first_divided_output,
        .first_divided_output_oe_n, .second_divided_output, .second_divided_output_oe_n,
        .external_trigger_pin, .third_count_pin, .rx_baud_tick, .tx_baud_tick,
        .third_overflow_pulse);
    initial begin
        forever #4 aclk = ~aclk;
    end
    // tallied on the falling edge so a tally never races a check at the rising edge
    always @(negedge aclk) begin
        if (tx_baud_tick === 1'b1) txn++;
        if (rx_baud_tick === 1'b1) rxn++;
        if (third_overflow_pulse === 1'b1) ovn++;
    end
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_bits(input logic [1:0] got, input logic [1:0] exp);
        cmp_val({30'h0, got}, {30'h0, exp});
    endtask
    function automatic bit mapped(input logic [7:0] idx);
        return idx inside {8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h93, 8'hC8, [8'hCA:8'hCD]};
    endfunction
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
        bit aw_ok, w_ok;
        logic [31:0] r;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        r = $random(seed);
        @(posedge aclk);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= {r[31:8], d};
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp_bits(bresp, mapped(idx) ? 2'h0 : 2'h2);
        if (mapped(idx) && st[0]) mdl[idx] = d;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        @(posedge aclk);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp_val(rdata, mapped(idx) ? {24'h0, e} : 32'h0);
        cmp_bits(rresp, mapped(idx) ? 2'h0 : 2'h2);
    endtask
    // one trigger fall with the given control value, then the flag and a data byte
    task automatic edge_case(input logic [7:0] c, input logic [7:0] ec, input logic [7:0] idx,
        input logic [7:0] e);
        wr(8'hCD, 8'h77, 4'h1);
        wr(8'hC8, c, 4'h1);
        @(posedge aclk);
        external_trigger_pin <= 1'b0;
        repeat (4) @(posedge aclk);
        external_trigger_pin <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(8'hC8, ec);
        rd(idx, e);
        wr(8'hC8, 8'h00, 4'h1);
    endtask
    task automatic give_verdict();
        $display("counts: checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        $display("watchdog expired");
        give_verdict();
    end
    initial begin
        for (i = 0; i < 256; i++) mdl[i] = 0;
        mdl[8'h93] = 8'h05;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 10; i++) rd(idxs[i], 8'(mdl[idxs[i]]));
        rd(8'h50, 8'h00);
        cmp_bits({first_divided_output_oe_n, second_divided_output_oe_n}, 2'h3);
        $display("test reset values done");
        for (i = 0; i < 10; i++) begin
            if (i == 4 || i == 5) continue;
            wr(idxs[i], 8'($random(seed)), 4'h1);
            rd(idxs[i], 8'(mdl[idxs[i]]));
        end
        cmp_val({16'h0, first_count}, {16'h0, 8'(mdl[8'h8C]), 8'(mdl[8'h8A])});
        cmp_val({16'h0, second_count}, {16'h0, 8'(mdl[8'h8D]), 8'(mdl[8'h8B])});
        wr(8'h8A, 8'h5A, 4'h0);
        rd(8'h8A, 8'(mdl[8'h8A]));
        wr(8'h40, 8'hFF, 4'h1);
        rd(8'h40, 8'h00);
        $display("test count bytes done");
        wr(8'h93, 8'h35, 4'h1);
        rd(8'h93, 8'h35);
        cmp_bits({first_divided_output_oe_n, second_divided_output_oe_n}, 2'h0);
        for (i = 0; i < 64; i++) begin
            @(posedge aclk);
            first_overflow <= 1'b1;
            second_overflow <= 1'b1;
            @(posedge aclk);
            first_overflow <= 1'b0;
            second_overflow <= 1'b0;
            @(posedge aclk);
            cmp_bits({first_divided_output, second_divided_output},
                {1'(((i + 1) / 32) % 2), 1'((i + 1) % 2)});
        end
        // a pulse while the clock enable is low must move nothing
        @(posedge aclk);
        ce <= 1'b0;
        second_overflow <= 1'b1;
        @(posedge aclk);
        second_overflow <= 1'b0;
        ce <= 1'b1;
        @(posedge aclk);
        cmp_bits({1'b0, second_divided_output}, 2'h0);
        cmp_val(32'(txn), 32'd64);
        cmp_val(32'(rxn), 32'd64);
        wr(8'h93, 8'h05, 4'h1);
        cmp_bits({first_divided_output_oe_n, second_divided_output_oe_n}, 2'h3);
        $display("test divided pins done");
        wr(8'hC8, 8'hFB, 4'h1);
        rd(8'hC8, 8'hFB);
        wr(8'hC8, 8'h00, 4'h1);
        rd(8'hC8, 8'h00);
        // overflow in plain mode, then in baud mode where the flag must stay clear
        wr(8'hCA, 8'h34, 4'h1);
        wr(8'hCB, 8'h12, 4'h1);
        for (i = 0; i < 4; i++) begin
            wr(8'hCC, 8'hFE, 4'h1);
            wr(8'hCD, 8'hFF, 4'h1);
            ovn = 0;
            t0 = txn;
            r0 = rxn;
            wr(8'hC8, ctl[i], 4'h1);
            repeat (8) @(posedge aclk);
            rd(8'hC8, i ? ctl[i] : 8'h84);
            wr(8'hC8, 8'h00, 4'h1);
            rd(8'hCD, 8'h12);
            cmp_val(32'(ovn), 32'd1);
            cmp_val(32'(txn - t0), {31'h0, ctl[i][4]});
            cmp_val(32'(rxn - r0), {31'h0, ctl[i][5]});
        end
        $display("test overflow flag done");
        edge_case(8'h08, 8'h48, 8'hCD, 8'h12);
        edge_case(8'h09, 8'h49, 8'hCB, 8'h77);
        edge_case(8'h00, 8'h00, 8'hCD, 8'h77);
        $display("test edge flag done");
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'hC8, 8'h00);
        rd(8'h93, 8'h05);
        $display("test second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
